// ---- rtl/dcarb_pkg.sv ----
package dcarb_pkg;

    // Region codes carried with inbound and copy-engine requests
    localparam logic [1:0] RGN_L1D = 2'h0;
    localparam logic [1:0] RGN_L1P = 2'h1;
    localparam logic [1:0] RGN_L2 = 2'h2;
    localparam logic [1:0] RGN_CFG = 2'h3;

    // Non-cacheable write buffer depth
    localparam int NC_DEPTH = 4;

    // Kinds of traffic leaving on the outbound system port
    typedef enum logic [1:0] {
        DCARB_OB_ALLOC,
        DCARB_OB_WBACK,
        DCARB_OB_NC_RD,
        DCARB_OB_NC_WR
    } dcarb_ob_kind_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [1:0]  region;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dcarb_req_s;

    typedef struct packed {
        logic           valid;
        dcarb_ob_kind_e kind;
        logic [31:0]    addr;
        logic [31:0]    wdata;
    } dcarb_ob_s;

endpackage

// ---- rtl/dcarb_top.sv ----
// Behaviour
// - Outbound port carries allocates, write-backs and non-cacheable stores.
// - Inbound slave port gives outside masters access to L1D, L1P and L2 RAM.
// - Copy engine moves data among L1, L2 and config bus, sharing inbound datapath.
// - L1D and L2 are write-back; victims only on need or request; L1D victims to L2.
// - Cache requests are pipelined; several may be outstanding at once.
// - Four-entry non-cacheable write buffer; full buffer blocks inbound and copy L2 traffic unless L2 is all cache.
// - L1D read miss with victim stalls only on L2 miss, until external data returns.
// - L1D read going external with another L1D request pending holds until complete.
// - L2 victim write-back during pending L1D request holds until both finish.
// - L1 accesses stall only when queued behind L2 accesses.
// - No extra stall when L2 is all cache or L2 RAM sees no traffic.
// - Copy-engine stall never deadlocks; only inbound L2 traffic can.
// - Outbound accesses may wait arbitrarily long; the core tolerates it.
// - While stalled, inbound port shows not-ready to L2 accesses and takes no L2 write data.
module dcarb_top #(
    parameter int NC_DEPTH = dcarb_pkg::NC_DEPTH // Non-cacheable buffer entries
) (
    input wire logic core_clk_i, // Core clock, 20 MHz
    input wire logic rst_n_i, // Async reset, active low
    input wire logic l2_all_cache_i, // L2 configured entirely as cache
    input wire dcarb_pkg::dcarb_req_s isp_req_i, // Inbound slave port request
    output logic isp_ready_o, // Inbound request accepted this cycle
    output logic [31:0] isp_rdata_o, // Inbound read data
    output logic isp_rvalid_o, // Inbound read data valid
    input wire dcarb_pkg::dcarb_req_s ice_req_i, // Internal copy engine request
    output logic ice_ready_o, // Copy request accepted this cycle
    input wire dcarb_pkg::dcarb_req_s nc_wr_i, // Core non-cacheable write
    output logic nc_ready_o, // Non-cacheable buffer has room
    input wire logic l1d_rd_miss_i, // L1D read miss pulse
    input wire logic l1d_victim_i, // That miss also evicts a dirty line
    input wire logic l2_miss_i, // That miss also misses L2
    input wire logic l1d_pend_i, // Another L1D request pending
    input wire logic l1d_done_i, // Pending L1D request finished
    input wire logic l2_victim_i, // L2 dirty line eviction pulse
    input wire logic [31:0] l2_victim_addr_i, // Address of L2 victim
    input wire logic [31:0] miss_addr_i, // Address of the L1D miss
    output dcarb_pkg::dcarb_ob_s ob_req_o, // Outbound system port request
    input wire logic ob_ready_i, // Outbound request taken
    input wire logic ob_done_i, // External access completed
    output logic stall_o // Inbound and copy L2 traffic held
);

    // ----------------------------------------------------------------
    // Non-cacheable write buffer
    // ----------------------------------------------------------------
    localparam int PW = $clog2(NC_DEPTH);
    logic [31:0] nc_addr [NC_DEPTH];
    logic [31:0] nc_data [NC_DEPTH];
    logic [PW-1:0] nc_wp;
    logic [PW-1:0] nc_rp;
    logic [PW:0] nc_cnt;
    logic nc_full;
    logic nc_push;
    logic nc_pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(NC_DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign nc_full = (nc_cnt == (PW+1)'(NC_DEPTH));
    assign nc_ready_o = !nc_full;
    assign nc_push = nc_wr_i.valid && !nc_full;

    always_ff @(posedge core_clk_i) begin
        if (nc_push) begin
            nc_addr[nc_wp] <= nc_wr_i.addr;
            nc_data[nc_wp] <= nc_wr_i.wdata;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nc_wp <= '0;
            nc_rp <= '0;
            nc_cnt <= '0;
        end else begin
            if (nc_push) nc_wp <= ptr_inc(nc_wp);
            if (nc_pop) nc_rp <= ptr_inc(nc_rp);
            nc_cnt <= nc_cnt + (PW+1)'(nc_push) - (PW+1)'(nc_pop);
        end
    end

    // ----------------------------------------------------------------
    // Cache miss and victim tracking
    // ----------------------------------------------------------------
    // Outstanding outbound work: fill, victim write-back, pending L1D
    logic fill_wait;
    logic ext_wait;
    logic l2v_wait;
    logic l1_pend_wait;
    logic l2v_ext_done; // Victim write-back already finished outside
    logic alloc_pend;
    logic wback_pend;
    logic [31:0] alloc_addr;
    logic [31:0] wback_addr;
    logic ob_busy;

    // Victims of L1D land in L2 and do not reach the outbound port
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fill_wait <= 1'b0;
            ext_wait <= 1'b0;
            alloc_pend <= 1'b0;
            alloc_addr <= '0;
        end else if (l1d_rd_miss_i && l2_miss_i) begin
            fill_wait <= l1d_victim_i;
            ext_wait <= l1d_pend_i;
            alloc_pend <= 1'b1;
            alloc_addr <= miss_addr_i;
        end else begin
            if (ob_req_o.valid && ob_req_o.kind == dcarb_pkg::DCARB_OB_ALLOC && ob_ready_i)
                alloc_pend <= 1'b0;
            if (ob_done_i && !alloc_pend) begin
                fill_wait <= 1'b0;
                ext_wait <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l2v_wait <= 1'b0;
            l2v_ext_done <= 1'b0;
            wback_pend <= 1'b0;
            wback_addr <= '0;
        end else if (l2_victim_i) begin
            l2v_wait <= l1d_pend_i;
            l2v_ext_done <= 1'b0;
            wback_pend <= 1'b1;
            wback_addr <= l2_victim_addr_i;
        end else begin
            if (ob_req_o.valid && ob_req_o.kind == dcarb_pkg::DCARB_OB_WBACK && ob_ready_i)
                wback_pend <= 1'b0;
            // Completion may come before or after the pending L1D request ends
            if (ob_done_i && !wback_pend)
                l2v_ext_done <= 1'b1;
            if ((l2v_ext_done || (ob_done_i && !wback_pend)) && !l1_pend_wait)
                l2v_wait <= 1'b0;
        end
    end

    // Set wins over clear for the pending-request flag
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) l1_pend_wait <= 1'b0;
        else if (l2_victim_i && l1d_pend_i) l1_pend_wait <= 1'b1;
        else if (l1d_done_i) l1_pend_wait <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Outbound system port arbitration
    // ----------------------------------------------------------------
    // Fills first (core waits on them), then write-backs, then NC writes.
    // Requests stay up with no timeout: outbound waits may be long.
    always_comb begin
        ob_req_o = '0;
        nc_pop = 1'b0;
        if (alloc_pend) begin
            ob_req_o.valid = 1'b1;
            ob_req_o.kind = dcarb_pkg::DCARB_OB_ALLOC;
            ob_req_o.addr = alloc_addr;
        end else if (wback_pend) begin
            ob_req_o.valid = 1'b1;
            ob_req_o.kind = dcarb_pkg::DCARB_OB_WBACK;
            ob_req_o.addr = wback_addr;
        end else if (nc_cnt != '0) begin
            ob_req_o.valid = 1'b1;
            ob_req_o.kind = dcarb_pkg::DCARB_OB_NC_WR;
            ob_req_o.addr = nc_addr[nc_rp];
            ob_req_o.wdata = nc_data[nc_rp];
            nc_pop = ob_ready_i;
        end
    end

    assign ob_busy = fill_wait || ext_wait || l2v_wait;

    // ----------------------------------------------------------------
    // Inbound and copy-engine arbitration
    // ----------------------------------------------------------------
    logic l2_queued; // An L2 request went unaccepted last cycle
    logic hold_l2;
    logic isp_l1;
    logic ice_l1;
    logic isp_go;
    logic ice_go;
    logic prio_ice;

    assign hold_l2 = !l2_all_cache_i && (nc_full || ob_busy);
    assign isp_l1 = isp_req_i.region != dcarb_pkg::RGN_L2;
    assign ice_l1 = ice_req_i.region != dcarb_pkg::RGN_L2;

    // L1 and config traffic passes unless queued behind a held L2 access
    assign isp_go = isp_req_i.valid && !(hold_l2 && (!isp_l1 || l2_queued));
    assign ice_go = ice_req_i.valid && !(hold_l2 && (!ice_l1 || l2_queued));
    // Shared datapath: one grant per cycle, alternating on contention
    assign isp_ready_o = isp_go && !(ice_go && prio_ice);
    assign ice_ready_o = ice_go && !isp_ready_o;
    assign stall_o = hold_l2;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l2_queued <= 1'b0;
            prio_ice <= 1'b0;
        end else begin
            if ((isp_req_i.valid && !isp_l1 && !isp_ready_o) ||
                (ice_req_i.valid && !ice_l1 && !ice_ready_o))
                l2_queued <= 1'b1;
            else
                l2_queued <= 1'b0;
            if (isp_ready_o && ice_go) prio_ice <= 1'b1;
            else if (ice_ready_o) prio_ice <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Local memory (region-sliced, small) for inbound reads and writes
    // ----------------------------------------------------------------
    logic [31:0] mem [64];
    logic [5:0] isp_idx;
    logic [5:0] ice_idx;
    assign isp_idx = {isp_req_i.region, isp_req_i.addr[5:2]};
    assign ice_idx = {ice_req_i.region, ice_req_i.addr[5:2]};

    always_ff @(posedge core_clk_i) begin
        if (isp_ready_o && isp_req_i.write) mem[isp_idx] <= isp_req_i.wdata;
        if (ice_ready_o && ice_req_i.write) mem[ice_idx] <= ice_req_i.wdata;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            isp_rvalid_o <= 1'b0;
            isp_rdata_o <= '0;
        end else begin
            isp_rvalid_o <= isp_ready_o && !isp_req_i.write;
            if (isp_ready_o && !isp_req_i.write) isp_rdata_o <= mem[isp_idx];
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_nc_full;
        nc_full && !l2_all_cache_i;
    endsequence

    a_nc_full_blocks: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        s_nc_full |-> stall_o)
        else $error("full write buffer did not stall");
    a_nc_cnt_bound: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        nc_cnt <= (PW+1)'(NC_DEPTH))
        else $error("write buffer overfilled");
    a_fill_holds: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (l1d_rd_miss_i && l2_miss_i && l1d_victim_i && !l2_all_cache_i) |=> stall_o)
        else $error("miss with victim did not stall");
    a_ext_pend: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (l1d_rd_miss_i && l2_miss_i && l1d_pend_i) |=> ext_wait)
        else $error("external read with pending not held");
    a_l2v_both: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (l2v_wait && l1_pend_wait) |=> l2v_wait)
        else $error("victim hold released early");
    a_cache_nostall: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        l2_all_cache_i |-> !stall_o)
        else $error("stall with all-cache L2");
    a_l1_passes: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (isp_req_i.valid && isp_l1 && !l2_queued && !ice_req_i.valid) |-> isp_ready_o)
        else $error("L1 access stalled with no L2 ahead");
    a_isp_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (isp_req_i.valid && !isp_l1 && stall_o) |-> !isp_ready_o)
        else $error("inbound accepted while stalled");
    a_one_grant: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !(isp_ready_o && ice_ready_o))
        else $error("double grant on shared path");
    a_rd_data: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (isp_ready_o && !isp_req_i.write) |=> isp_rvalid_o)
        else $error("read data not returned");
    a_rvalid_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (isp_rvalid_o && !(isp_ready_o && !isp_req_i.write)) |=> !isp_rvalid_o)
        else $error("read valid stood too long");
    a_ice_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (ice_req_i.valid && !ice_l1 && stall_o) |-> !ice_ready_o)
        else $error("copy engine accepted while stalled");
    a_alloc_first: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        alloc_pend |-> (ob_req_o.valid && ob_req_o.kind == dcarb_pkg::DCARB_OB_ALLOC))
        else $error("fill not presented first");
    a_ob_held: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (ob_req_o.valid && !ob_ready_i) |=> ob_req_o.valid)
        else $error("outbound request dropped before taken");
    a_fill_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (fill_wait && ob_done_i && !alloc_pend && !l1d_rd_miss_i) |=> !fill_wait)
        else $error("fill hold not released");
    a_ext_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (ext_wait && ob_done_i && !alloc_pend && !l1d_rd_miss_i) |=> !ext_wait)
        else $error("external hold not released");
    a_l2v_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (l2v_wait && l2v_ext_done && !l1_pend_wait && !l2_victim_i) |=> !l2v_wait)
        else $error("victim hold not released");

endmodule

// ---- testbench/dcarb_ob_model.sv ----
// ----------------------------------------
// External memory behind the outbound port
// ----------------------------------------
module dcarb_ob_model (
    input wire logic clk_i, // Core clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic hold_i, // Slow memory: take nothing while high
    input wire dcarb_pkg::dcarb_ob_s req_i, // Outbound request
    output logic ready_o, // Request taken
    output logic done_o, // External access finished
    output int ncwr_cnt_o, // Non-cacheable writes taken
    output int done_cnt_o // Completions given
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] lag;
    // Allocates and write-backs finish a few cycles after being taken
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_o <= 1'b0;
            done_o <= 1'b0;
            lag <= 2'h0;
            ncwr_cnt_o <= 0;
            done_cnt_o <= 0;
        end else begin
            ready_o <= req_i.valid && !hold_i && !ready_o;
            done_o <= (lag == 2'h1);
            lag <= (lag != 2'h0) ? lag - 2'h1 : 2'h0;
            if (done_o) done_cnt_o <= done_cnt_o + 1;
            if (ready_o && req_i.valid) begin
                if (req_i.kind == dcarb_pkg::DCARB_OB_NC_WR) ncwr_cnt_o <= ncwr_cnt_o + 1;
                else lag <= 2'h3;
            end
        end
    end
endmodule

// ---- testbench/dcarb_top_bench.sv ----
module dcarb_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i, rst_n_i, l2_all_cache_i, ob_hold, ob_ready_i, ob_done_i, stall_o;
    logic l1d_rd_miss_i, l1d_victim_i, l2_miss_i, l1d_pend_i, l1d_done_i, l2_victim_i;
    logic isp_ready_o, isp_rvalid_o, ice_ready_o, nc_ready_o;
    logic [31:0] l2_victim_addr_i, miss_addr_i, isp_rdata_o;
    dcarb_pkg::dcarb_req_s isp_req_i, ice_req_i, nc_wr_i;
    dcarb_pkg::dcarb_ob_s ob_req_o;
    int ncwr_cnt, done_cnt, fail_count, checked, d0;
    logic [1:0] rg [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
    logic [31:0] ad [6] = '{32'h0, 32'h4, 32'h3C, 32'h8, 32'h3C, 32'h0};
    logic [31:0] dt [6] = '{32'hA5A5_0001, 32'h5A5A_0002, 32'hFFFF_0003,
                            32'h1234_5678, 32'h0000_00FF, 32'hDEAD_BEEF};

    dcarb_top dcarb_top_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .l2_all_cache_i(l2_all_cache_i), .isp_req_i(isp_req_i), .isp_ready_o(isp_ready_o),
        .isp_rdata_o(isp_rdata_o), .isp_rvalid_o(isp_rvalid_o), .ice_req_i(ice_req_i),
        .ice_ready_o(ice_ready_o), .nc_wr_i(nc_wr_i), .nc_ready_o(nc_ready_o),
        .l1d_rd_miss_i(l1d_rd_miss_i), .l1d_victim_i(l1d_victim_i), .l2_miss_i(l2_miss_i),
        .l1d_pend_i(l1d_pend_i), .l1d_done_i(l1d_done_i), .l2_victim_i(l2_victim_i),
        .l2_victim_addr_i(l2_victim_addr_i), .miss_addr_i(miss_addr_i),
        .ob_req_o(ob_req_o), .ob_ready_i(ob_ready_i), .ob_done_i(ob_done_i),
        .stall_o(stall_o));
    dcarb_ob_model dcarb_ob_model_i (.clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .hold_i(ob_hold), .req_i(ob_req_o), .ready_o(ob_ready_i), .done_o(ob_done_i),
        .ncwr_cnt_o(ncwr_cnt), .done_cnt_o(done_cnt));

    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (e !== g) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Outside masters hold the request until ready is seen at an edge
    task automatic wait_rdy(input int k);
        int n;
        logic [2:0] r;
        n = 0;
        forever begin
            @(negedge core_clk_i);
            r = {nc_ready_o, ice_ready_o, isp_ready_o};
            if (r[k] === 1'b1 || n == 400) break;
            n++;
        end
        if (n == 400) chk("ready", 32'h1, 32'h0);
        @(posedge core_clk_i);
    endtask

    task automatic isp_go(input logic w, input logic [1:0] g, input logic [31:0] a, d);
        @(posedge core_clk_i);
        isp_req_i <= '{1'b1, w, g, a, d};
    endtask

    task automatic isp_end(input logic w, input logic [31:0] e);
        wait_rdy(0);
        isp_req_i <= '0;
        if (!w) begin
            @(negedge core_clk_i);
            chk("isp_rvalid_o", 32'h1, {31'h0, isp_rvalid_o});
            chk("isp_rdata_o", e, isp_rdata_o);
        end
    endtask

    task automatic nc_put(input logic [31:0] a);
        @(posedge core_clk_i);
        nc_wr_i <= '{1'b1, 1'b1, dcarb_pkg::RGN_L1D, a, ~a};
        wait_rdy(2);
        nc_wr_i <= '0;
    endtask

    task automatic miss(input logic vic, input logic pend);
        @(posedge core_clk_i);
        ob_hold <= 1'b1;
        {l1d_rd_miss_i, l1d_victim_i, l2_miss_i, l1d_pend_i} <= {1'b1, vic, 1'b1, pend};
        miss_addr_i <= 32'h8000_0040;
        @(posedge core_clk_i);
        {l1d_rd_miss_i, l1d_victim_i, l2_miss_i, l1d_pend_i} <= 4'h0;
    endtask

    task automatic report_and_stop;
        if (fail_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        fail_count++;
        report_and_stop;
    end

    initial begin
        {rst_n_i, l2_all_cache_i, ob_hold, l1d_rd_miss_i, l1d_victim_i} <= 5'h0;
        {l2_miss_i, l1d_pend_i, l1d_done_i, l2_victim_i} <= 4'h0;
        {l2_victim_addr_i, miss_addr_i} <= 64'h0;
        {isp_req_i, ice_req_i, nc_wr_i} <= '0;
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(negedge core_clk_i);
        chk("nc_ready_o", 32'h1, {31'h0, nc_ready_o});
        chk("stall_o", 32'h0, {31'h0, stall_o});
        // -------------------------
        // Ordinary region accesses
        // -------------------------
        for (int i = 0; i < 6; i++) begin
            isp_go(1'b1, rg[i], ad[i], dt[i]);
            isp_end(1'b1, 32'h0);
        end
        for (int i = 0; i < 6; i++) begin
            isp_go(1'b0, rg[i], ad[i], 32'h0);
            isp_end(1'b0, dt[i]);
        end
        @(posedge core_clk_i);
        ice_req_i <= '{1'b1, 1'b1, dcarb_pkg::RGN_L1D, 32'h10, 32'hC0DE_0010};
        wait_rdy(1);
        ice_req_i <= '0;
        isp_go(1'b0, dcarb_pkg::RGN_L1D, 32'h10, 32'h0);
        isp_end(1'b0, 32'hC0DE_0010);
        @(posedge core_clk_i);
        isp_req_i <= '{1'b1, 1'b0, dcarb_pkg::RGN_L1D, 32'h0, 32'h0};
        ice_req_i <= '{1'b1, 1'b1, dcarb_pkg::RGN_CFG, 32'h30, 32'h0BAD_0030};
        @(negedge core_clk_i);
        chk("isp_ready_o", 32'h1, {31'h0, isp_ready_o});
        chk("ice_ready_o", 32'h0, {31'h0, ice_ready_o});
        @(posedge core_clk_i);
        isp_req_i <= '0;
        @(negedge core_clk_i);
        chk("ice_ready_o", 32'h1, {31'h0, ice_ready_o});
        chk("isp_rdata_o", 32'hA5A5_0001, isp_rdata_o);
        @(posedge core_clk_i);
        ice_req_i <= '0;
        isp_go(1'b0, dcarb_pkg::RGN_CFG, 32'h30, 32'h0);
        isp_end(1'b0, 32'h0BAD_0030);
        // -----------------------------------------------
        // Full write buffer, slow memory, refused inbound
        // -----------------------------------------------
        ob_hold <= 1'b1;
        for (int i = 0; i < 4; i++) nc_put(32'h9000_0000 + 32'(i * 4));
        @(negedge core_clk_i);
        chk("nc_ready_o", 32'h0, {31'h0, nc_ready_o});
        chk("stall_o", 32'h1, {31'h0, stall_o});
        chk("ob_addr", 32'h9000_0000, ob_req_o.addr);
        chk("ob_wdata", 32'h6FFF_FFFF, ob_req_o.wdata);
        isp_go(1'b0, dcarb_pkg::RGN_L1D, 32'h3C, 32'h0);
        isp_end(1'b0, 32'h0000_00FF);
        isp_go(1'b1, dcarb_pkg::RGN_L2, 32'h20, 32'h7777_7777);
        repeat (3) begin
            @(negedge core_clk_i);
            chk("isp_ready_o", 32'h0, {31'h0, isp_ready_o});
        end
        ob_hold <= 1'b0;
        isp_end(1'b1, 32'h0);
        repeat (12) @(posedge core_clk_i);
        chk("ncwr_cnt", 32'h4, 32'(ncwr_cnt));
        // ------------------------------------------
        // Read misses going external hold the ports
        // ------------------------------------------
        for (int v = 0; v < 2; v++) begin
            d0 = done_cnt;
            miss(v == 0, v == 1);
            @(negedge core_clk_i);
            chk("stall_o", 32'h1, {31'h0, stall_o});
            chk("ob_valid", 32'h1, {31'h0, ob_req_o.valid});
            chk("ob_kind", 32'(dcarb_pkg::DCARB_OB_ALLOC), 32'(ob_req_o.kind));
            chk("ob_addr", 32'h8000_0040, ob_req_o.addr);
            ob_hold <= 1'b0;
            for (int n = 0; n < 40 && stall_o !== 1'b0; n++) @(negedge core_clk_i);
            chk("stall_o", 32'h0, {31'h0, stall_o});
            chk("done_cnt", 32'(d0 + 1), 32'(done_cnt));
        end
        // ---------------------------------------------
        // Write-back held until both sides have finished
        // ---------------------------------------------
        @(posedge core_clk_i);
        {l2_victim_i, l1d_pend_i, l2_victim_addr_i} <= {2'h3, 32'h8000_0100};
        @(posedge core_clk_i);
        {l2_victim_i, l1d_pend_i} <= 2'h0;
        d0 = done_cnt;
        for (int n = 0; n < 40 && done_cnt == d0; n++) @(negedge core_clk_i);
        repeat (2) @(negedge core_clk_i);
        chk("stall_o", 32'h1, {31'h0, stall_o});
        @(posedge core_clk_i);
        l1d_done_i <= 1'b1;
        @(posedge core_clk_i);
        l1d_done_i <= 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk("stall_o", 32'h0, {31'h0, stall_o});
        // -------------------------------------
        // L2 all cache: a full buffer holds nothing
        // -------------------------------------
        @(posedge core_clk_i);
        l2_all_cache_i <= 1'b1;
        ob_hold <= 1'b1;
        for (int i = 0; i < 4; i++) nc_put(32'h9100_0000 + 32'(i * 4));
        @(negedge core_clk_i);
        chk("stall_o", 32'h0, {31'h0, stall_o});
        isp_go(1'b0, dcarb_pkg::RGN_L1P, 32'h4, 32'h0);
        isp_end(1'b0, 32'h5A5A_0002);
        ob_hold <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        report_and_stop;
    end
endmodule
